// ### src/adc_seq_pkg.sv
package adc_seq_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SOFTWARE_START_BIT_TIME_NS = 5900;
  localparam int SOFTWARE_START_BIT_TIME_CYCLES = (SOFTWARE_START_BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int ACQ_TIME_NS = 2000;
  localparam int ACQ_TIME_CYCLES = (ACQ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int QUIET_TIME_NS = 500;
  localparam int QUIET_TIME_CYCLES = (QUIET_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SOFTWARE_START_BIT_HALF_MCLKS = 29;
  localparam int SETTLE_SCLK_EDGE = 6;
  localparam int SETTLE_CYCLES_DEF = 250;
  localparam int FULL_SPEC_RATE_KHZ = 117;
  localparam int DEGRADED_RATE_KHZ = 127;
  localparam int SELF_CLOCK_RATE_KHZ = 78;

  // ---------------------------------------------------------------
  // Data widths and reset values
  // ---------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int CHAN_W = 3;
  localparam int CODE_MSB = RESULT_W - 1;
  localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic software_start_bit;
    logic standby;
  } ctrl_word_type;

  localparam ctrl_word_type CTRL_RST = '{channel: 3'h0, software_start_bit: 1'b0, standby: 1'b0};

  typedef struct packed {
    logic busy;
    logic hold;
    logic acquired;
    logic sw_pending;
    logic late;
  } status_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SW_WAIT = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_type;

endpackage

// ### src/adc_settle_timer.sv
`timescale 1ns/100ps
module adc_settle_timer
  import adc_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic drop_in,
  input wire logic discharge_in,
  output logic active_out,
  output logic timing_capacitor_pin_out
);

  // ---------------------------------------------------------------
  // Settling interval
  // ---------------------------------------------------------------
  logic low_r;
  logic low_nxt;
  logic run_r;
  logic run_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  always_comb begin
    low_nxt = low_r;
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    // [RL4] Drop at write start.
    if (drop_in) begin
      low_nxt = 1'b1;
      run_nxt = 1'b0;
    end
    // [RL4] Discharge from sixth edge.
    if (discharge_in) begin
      low_nxt = 1'b1;
      run_nxt = 1'b1;
      cnt_nxt = CNT_W'(SETTLE_CYCLES);
    end else if (run_r && !drop_in) begin
      // [RL5] Threshold crossing ends interval.
      if (cnt_r <= CNT_W'(1)) begin
        run_nxt = 1'b0;
        low_nxt = 1'b0;
        cnt_nxt = '0;
      end else begin
        cnt_nxt = cnt_r - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      low_r <= 1'b0;
      run_r <= 1'b0;
      cnt_r <= '0;
    end else if (ce_in) begin
      low_r <= low_nxt;
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign active_out = low_r;
  assign timing_capacitor_pin_out = ~low_r;

endmodule

// ### src/adc_conversion_sequencer.sv
`timescale 1ns/100ps
// Overview of operation
// [RL1] Start by pin strobe or software bit.
// [RL2] Pin rising edge holds, converts if settled.
// [RL3] Channel load launches settling interval.
// [RL4] Settling drops at write, discharges sixth edge.
// [RL5] No hold until settling threshold crossed.
// [RL6] Every write retriggers; software start delayed.
// [RL7] Conversion clock comes from master clock.
// [RL8] Conversion finishes within 5.9 us.
// [RL9] Track/hold acquires within 2 us.
// [RL10] Conversion end returns to track mode.
// [RL11] Host keeps quiet during conversion, 500 ns before.
// [RL12] Throughput 117/127 kHz external, 78 self.
// [RL13] Bipolar variant outputs twos complement.
// [RL14] Unipolar variants output straight binary.
// [RL15] Codes step at integer LSB multiples.
// [RL16] Software start samples at settling expiry.
// [RL17] Conversion lasts 14.5 master clocks.
// [RL18] Software bit set disables start pin.
// [RL19] Self-clocking end drops receive frame sync.
// [RL20] Conversion end latches newest result.
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter bit BIPOLAR = 1'b0,
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_DEF,
  parameter int SETTLE_CNT_W = 16
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  input wire logic conversion_start_pin_in,
  input wire logic master_clock_in,
  input wire logic write_begin_in,
  input wire logic write_end_in,
  input wire logic sclk_fall_in,
  input wire ctrl_word_type write_word_in,
  input wire logic self_clock_mode_in,
  input wire logic frame_done_in,
  input wire logic [RESULT_W-1:0] raw_code_in,
  output logic timing_capacitor_pin_out,
  output logic track_hold_out,
  output logic receive_frame_sync_n_out,
  output logic [RESULT_W-1:0] result_out,
  output logic [CHAN_W-1:0] channel_out,
  output logic standby_out,
  output logic eoc_out,
  output status_type status_out
);

  // ---------------------------------------------------------------
  // Input edge detection
  // ---------------------------------------------------------------
  logic pin_d_r;
  logic mclk_d_r;
  logic pin_rise;
  logic mclk_edge;

  assign pin_rise = conversion_start_pin_in & ~pin_d_r;
  // [RL7] Both master clock edges.
  assign mclk_edge = master_clock_in ^ mclk_d_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_d_r <= 1'b0;
      mclk_d_r <= 1'b0;
    end else if (ce_in) begin
      pin_d_r <= conversion_start_pin_in;
      mclk_d_r <= master_clock_in;
    end
  end

  // ---------------------------------------------------------------
  // Serial write and control register
  // ---------------------------------------------------------------
  logic wr_active_r;
  logic wr_active_nxt;
  logic [2:0] sclk_cnt_r;
  logic [2:0] sclk_cnt_nxt;
  ctrl_word_type ctrl_r;
  ctrl_word_type ctrl_nxt;
  logic load;
  logic settle_active;

  assign load = wr_active_r & sclk_fall_in & ~write_begin_in & (sclk_cnt_r == 3'(SETTLE_SCLK_EDGE - 1));

  always_comb begin
    wr_active_nxt = wr_active_r;
    sclk_cnt_nxt = sclk_cnt_r;
    ctrl_nxt = ctrl_r;
    if (write_begin_in) begin
      wr_active_nxt = 1'b1;
      sclk_cnt_nxt = 3'h0;
    end else if (write_end_in) begin
      wr_active_nxt = 1'b0;
    end else if (wr_active_r && sclk_fall_in && sclk_cnt_r != 3'(SETTLE_SCLK_EDGE)) begin
      sclk_cnt_nxt = sclk_cnt_r + 3'h1;
    end
    // [RL3] Channel load at sixth edge.
    if (load) begin
      ctrl_nxt = write_word_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_active_r <= 1'b0;
      sclk_cnt_r <= 3'h0;
      ctrl_r <= CTRL_RST;
    end else if (ce_in) begin
      wr_active_r <= wr_active_nxt;
      sclk_cnt_r <= sclk_cnt_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // [RL6] Each write retriggers settling.
  adc_settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES),
    .CNT_W(SETTLE_CNT_W)
  ) adc_settle_timer_inst (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ce_in(ce_in),
    .drop_in(write_begin_in),
    .discharge_in(load),
    .active_out(settle_active),
    .timing_capacitor_pin_out(timing_capacitor_pin_out)
  );

  // ---------------------------------------------------------------
  // Conversion sequence
  // ---------------------------------------------------------------
  seq_state_type state_r;
  seq_state_type state_nxt;
  logic [4:0] half_cnt_r;
  logic [4:0] half_cnt_nxt;
  logic [10:0] time_cnt_r;
  logic [10:0] time_cnt_nxt;
  logic late_r;
  logic late_nxt;
  logic hold_r;
  logic hold_nxt;
  logic [RESULT_W-1:0] result_r;
  logic [RESULT_W-1:0] result_nxt;
  logic eoc_r;
  logic eoc_nxt;
  logic start_go;
  logic software_start_bit_end;
  logic [RESULT_W-1:0] coded;

  // [RL13] Twos complement by MSB flip.
  // [RL14] Straight binary passes through.
  // [RL15] One code per LSB step.
  assign coded = BIPOLAR ? {~raw_code_in[CODE_MSB], raw_code_in[CODE_MSB-1:0]} : raw_code_in;

  // [RL2] Pin edge only when settled.
  // [RL18] Software bit masks the pin.
  assign start_go = pin_rise & ~settle_active & ~ctrl_r.software_start_bit;
  // [RL17] End after 14.5 master clocks.
  assign software_start_bit_end = (state_r == ST_CONVERT) & mclk_edge & (half_cnt_r == 5'(SOFTWARE_START_BIT_HALF_MCLKS - 1));

  always_comb begin
    state_nxt = state_r;
    half_cnt_nxt = half_cnt_r;
    time_cnt_nxt = time_cnt_r;
    late_nxt = late_r;
    hold_nxt = hold_r;
    result_nxt = result_r;
    eoc_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        // [RL1] Software start armed by write.
        if (load && write_word_in.software_start_bit) begin
          state_nxt = ST_SW_WAIT;
        // [RL1] Hardware pin start.
        end else if (start_go) begin
          state_nxt = ST_CONVERT;
          hold_nxt = 1'b1;
          half_cnt_nxt = 5'h00;
          time_cnt_nxt = 11'h000;
          late_nxt = 1'b0;
        end
      end
      ST_SW_WAIT: begin
        // [RL16] Sample at settling expiry.
        // [RL5] Wait for threshold.
        if (!settle_active) begin
          state_nxt = ST_CONVERT;
          hold_nxt = 1'b1;
          half_cnt_nxt = 5'h00;
          time_cnt_nxt = 11'h000;
          late_nxt = 1'b0;
        end
      end
      ST_CONVERT: begin
        if (time_cnt_r != 11'h7FF) begin
          time_cnt_nxt = time_cnt_r + 11'h001;
        end
        // [RL8] Flag overrun of 5.9 us.
        if (time_cnt_r == 11'(SOFTWARE_START_BIT_TIME_CYCLES)) begin
          late_nxt = 1'b1;
        end
        if (mclk_edge) begin
          half_cnt_nxt = half_cnt_r + 5'h01;
        end
        if (software_start_bit_end) begin
          // [RL10] Back to track mode.
          state_nxt = ST_IDLE;
          hold_nxt = 1'b0;
          // [RL20] Latch newest result.
          result_nxt = coded;
          eoc_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        hold_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= ST_IDLE;
      half_cnt_r <= 5'h00;
      time_cnt_r <= 11'h000;
      late_r <= 1'b0;
      hold_r <= 1'b0;
      result_r <= RESULT_RST;
      eoc_r <= 1'b0;
    end else if (ce_in) begin
      state_r <= state_nxt;
      half_cnt_r <= half_cnt_nxt;
      time_cnt_r <= time_cnt_nxt;
      late_r <= late_nxt;
      hold_r <= hold_nxt;
      result_r <= result_nxt;
      eoc_r <= eoc_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Acquisition and frame sync
  // ---------------------------------------------------------------
  logic [9:0] acq_cnt_r;
  logic [9:0] acq_cnt_nxt;
  logic rfs_low_r;
  logic rfs_low_nxt;

  always_comb begin
    acq_cnt_nxt = acq_cnt_r;
    rfs_low_nxt = rfs_low_r;
    // [RL9] Acquisition timed from track return.
    if (hold_r) begin
      acq_cnt_nxt = 10'h000;
    end else if (acq_cnt_r != 10'(ACQ_TIME_CYCLES)) begin
      acq_cnt_nxt = acq_cnt_r + 10'h001;
    end
    // [RL19] Frame sync low at end.
    if (software_start_bit_end && self_clock_mode_in) begin
      rfs_low_nxt = 1'b1;
    end else if (frame_done_in) begin
      rfs_low_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acq_cnt_r <= 10'(ACQ_TIME_CYCLES);
      rfs_low_r <= 1'b0;
    end else if (ce_in) begin
      acq_cnt_r <= acq_cnt_nxt;
      rfs_low_r <= rfs_low_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // [RL10] Track/hold follows sequencer.
  assign track_hold_out = hold_r;
  // [RL19] Frame sync active low.
  assign receive_frame_sync_n_out = ~rfs_low_r;
  // [RL20] Registered newest result.
  assign result_out = result_r;
  // [RL3] Selected multiplexer channel.
  assign channel_out = ctrl_r.channel;
  assign standby_out = ctrl_r.standby;
  // [RL10] One-cycle end strobe.
  assign eoc_out = eoc_r;
  // [RL1] Busy from either start.
  assign status_out.busy = (state_r != ST_IDLE);
  assign status_out.hold = hold_r;
  // [RL9] Acquisition time elapsed.
  // [RL12] Next sample may start.
  assign status_out.acquired = ~hold_r & (acq_cnt_r == 10'(ACQ_TIME_CYCLES));
  // [RL16] Waiting for settling expiry.
  assign status_out.sw_pending = (state_r == ST_SW_WAIT);
  // [RL8] Conversion overran.
  assign status_out.late = late_r;

endmodule

// ### tb/adc_seq_chk.sv
`timescale 1ns/100ps
module adc_seq_chk
  import adc_seq_pkg::*;
#(
  parameter bit BIPOLAR = 1'b0
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic conversion_start_pin_in,
  input wire logic master_clock_in,
  input wire logic write_begin_in,
  input wire logic sclk_fall_in,
  input wire ctrl_word_type write_word_in,
  input wire logic self_clock_mode_in,
  input wire logic [RESULT_W-1:0] raw_code_in,
  input wire logic timing_capacitor_pin_out,
  input wire logic track_hold_out,
  input wire logic receive_frame_sync_n_out,
  input wire logic [RESULT_W-1:0] result_out,
  input wire logic eoc_out,
  input wire status_type status_out
);
  logic mc_r;
  logic sw_r;
  logic [5:0] mcnt_r;
  logic [2:0] fcnt_r;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      mc_r <= 1'b0;
      sw_r <= 1'b0;
      mcnt_r <= 6'h00;
      fcnt_r <= 3'h0;
    end else begin
      mc_r <= master_clock_in;
      mcnt_r <= !track_hold_out ? 6'h00 : mcnt_r + 6'(master_clock_in != mc_r);
      fcnt_r <= write_begin_in ? 3'h0 : fcnt_r + 3'(sclk_fall_in && fcnt_r < 3'h6);
      if (sclk_fall_in && fcnt_r == 3'h5) begin
        sw_r <= write_word_in.software_start_bit;
      end
    end
  end
  property p_settled; $rose(track_hold_out) |-> $past(timing_capacitor_pin_out); endproperty
  a_settled: assert property (p_settled) else $error("hold while settling");
  property p_end; $fell(track_hold_out) |-> eoc_out; endproperty
  a_end: assert property (p_end) else $error("track without end strobe");
  property p_code; eoc_out |-> result_out == ($past(raw_code_in) ^ {BIPOLAR, {CODE_MSB{1'b0}}}); endproperty
  a_code: assert property (p_code) else $error("result code wrong");
  property p_len; $fell(track_hold_out) |-> mcnt_r == SOFTWARE_START_BIT_HALF_MCLKS; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_drop; write_begin_in |=> !timing_capacitor_pin_out; endproperty
  a_drop: assert property (p_drop) else $error("settling not dropped");
  property p_sw; status_out.sw_pending && timing_capacitor_pin_out && !track_hold_out |=> track_hold_out; endproperty
  a_sw: assert property (p_sw) else $error("software start late");
  property p_rfs; eoc_out && self_clock_mode_in |-> !receive_frame_sync_n_out; endproperty
  a_rfs: assert property (p_rfs) else $error("frame sync not low");
  property p_hw;
    $rose(conversion_start_pin_in) && timing_capacitor_pin_out && !status_out.busy && !status_out.sw_pending
      && !sw_r |=> track_hold_out;
  endproperty
  a_hw: assert property (p_hw) else $error("pin start missed");
  property p_lock;
    $rose(conversion_start_pin_in) && sw_r && !track_hold_out && !status_out.sw_pending |=> !track_hold_out;
  endproperty
  a_lock: assert property (p_lock) else $error("pin start not locked");
  c_end: cover property ($fell(track_hold_out));
  c_self: cover property (eoc_out && self_clock_mode_in);
  c_sw: cover property (status_out.sw_pending && timing_capacitor_pin_out);
endmodule

// ### tb/adc_host_model.sv
`timescale 1ns/100ps
module adc_host_model
  import adc_seq_pkg::*;
(
  input wire logic clk_in,
  input wire logic go_in,
  input wire ctrl_word_type word_in,
  output logic master_clock_out,
  output logic write_begin_out,
  output logic sclk_fall_out,
  output logic write_end_out,
  output ctrl_word_type write_word_out,
  output logic busy_out
);
  logic [1:0] div_r;
  logic [4:0] step_r;
  ctrl_word_type word_r;
  initial begin
    div_r = 2'h0;
    step_r = 5'h00;
    word_r = CTRL_RST;
    master_clock_out = 1'b0;
  end
  // Master clock, one eighth of clk.
  always @(posedge clk_in) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3) begin
      master_clock_out <= ~master_clock_out;
    end
  end
  always @(posedge clk_in) begin
    if (go_in && step_r == 5'h00) begin
      step_r <= 5'h01;
      word_r <= word_in;
    end else if (step_r != 5'h00) begin
      step_r <= (step_r == 5'h11) ? 5'h00 : step_r + 5'h01;
    end
  end
  assign busy_out = (step_r != 5'h00);
  assign write_begin_out = (step_r == 5'h01);
  assign sclk_fall_out = step_r[0] && (step_r > 5'h02) && (step_r < 5'h10);
  assign write_end_out = (step_r == 5'h10);
  assign write_word_out = busy_out ? word_r : ~word_r;
endmodule

// ### tb/test_adc_conversion_sequencer.sv
`timescale 1ns/100ps
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic pin = 1'b0;
  logic self_mode = 1'b0;
  logic fdone = 1'b0;
  logic go = 1'b0;
  logic [RESULT_W-1:0] raw = 12'h000;
  ctrl_word_type word = CTRL_RST;
  ctrl_word_type wword;
  logic mclk, wbeg, wend, sfall, busy, tcap, hold, rfs_n, eoc, stby;
  logic [RESULT_W-1:0] result;
  logic [CHAN_W-1:0] chan;
  status_type stat;
  logic [RESULT_W-1:0] result_b;
  localparam int THRU_CYCLES = 1000000000 / (FULL_SPEC_RATE_KHZ * CLK_PERIOD_PS);
  int cyc = 0;
  int err_total = 0;
  int n_checks = 0;
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  adc_host_model adc_host_model_inst (.clk_in(clk_in), .go_in(go), .word_in(word), .master_clock_out(mclk),
    .write_begin_out(wbeg), .sclk_fall_out(sfall), .write_end_out(wend), .write_word_out(wword), .busy_out(busy));
  adc_conversion_sequencer #(.SETTLE_CYCLES(8)) adc_conversion_sequencer_inst (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .ce_in(1'b1), .conversion_start_pin_in(pin), .master_clock_in(mclk),
    .write_begin_in(wbeg), .write_end_in(wend), .sclk_fall_in(sfall), .write_word_in(wword),
    .self_clock_mode_in(self_mode), .frame_done_in(fdone), .raw_code_in(raw), .timing_capacitor_pin_out(tcap),
    .track_hold_out(hold), .receive_frame_sync_n_out(rfs_n), .result_out(result), .channel_out(chan),
    .standby_out(stby), .eoc_out(eoc), .status_out(stat));
  adc_conversion_sequencer #(.BIPOLAR(1'b1), .SETTLE_CYCLES(8))
    adc_conversion_sequencer_bipolar_inst (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .ce_in(1'b1), .conversion_start_pin_in(pin), .master_clock_in(mclk),
    .write_begin_in(wbeg), .write_end_in(wend), .sclk_fall_in(sfall), .write_word_in(wword),
    .self_clock_mode_in(self_mode), .frame_done_in(fdone), .raw_code_in(raw), .timing_capacitor_pin_out(),
    .track_hold_out(), .receive_frame_sync_n_out(), .result_out(result_b), .channel_out(),
    .standby_out(), .eoc_out(), .status_out());
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (e !== g) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_hold(input logic v);
    for (int i = 0; i < 400 && hold !== v; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (hold !== v) begin
      check("track_hold_wait", v, hold);
      finish_test;
    end
  endtask
  task automatic host_write(input ctrl_word_type w);
    @(posedge clk_in);
    word <= w;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(posedge clk_in);
      #1;
    end
    if (busy !== 1'b0) begin
      check("host_busy", 1'b0, busy);
      finish_test;
    end
  endtask
  task automatic t_hw(input logic [RESULT_W-1:0] code);
    int t0;
    @(posedge clk_in);
    raw <= code;
    pin <= 1'b1;
    wait_hold(1'b1);
    t0 = cyc;
    check("busy", 1'b1, stat.busy);
    @(posedge clk_in);
    pin <= 1'b0;
    wait_hold(1'b0);
    check("result", code, result);
    check("result_bipolar", code ^ 12'h800, result_b);
    check("eoc", 1'b1, eoc);
    check("late", 1'b0, stat.late);
    check("acquired_early", 1'b0, stat.acquired);
    n_checks++;
    if (cyc - t0 > SOFTWARE_START_BIT_TIME_CYCLES) begin
      err_total++;
      $display("mismatch software_start_bit_cycles expected %0d seen %0d", SOFTWARE_START_BIT_TIME_CYCLES, cyc - t0);
    end
    n_checks++;
    if (cyc - t0 + ACQ_TIME_CYCLES > THRU_CYCLES) begin
      err_total++;
      $display("mismatch throughput_cycles expected %0d seen %0d", THRU_CYCLES, cyc - t0 + ACQ_TIME_CYCLES);
    end
    repeat (ACQ_TIME_CYCLES) @(posedge clk_in);
    #1 check("acquired", 1'b1, stat.acquired);
  endtask
  task automatic t_settle;
    host_write('{channel: 3'h5, software_start_bit: 1'b0, standby: 1'b0});
    check("channel", 3'h5, chan);
    check("settle_pin", 1'b0, tcap);
    @(posedge clk_in);
    pin <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1 check("blocked_hold", 1'b0, hold);
    @(posedge clk_in);
    pin <= 1'b0;
    repeat (ACQ_TIME_CYCLES) @(posedge clk_in);
    t_hw(12'h5A3);
  endtask
  task automatic t_sw;
    @(posedge clk_in);
    raw <= 12'h3C1;
    host_write('{channel: 3'h2, software_start_bit: 1'b1, standby: 1'b0});
    check("sw_pending", 1'b1, stat.sw_pending);
    wait_hold(1'b1);
    check("settle_pin", 1'b1, tcap);
    wait_hold(1'b0);
    check("result", 12'h3C1, result);
    repeat (ACQ_TIME_CYCLES) @(posedge clk_in);
    @(posedge clk_in);
    pin <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check("locked_hold", 1'b0, hold);
    @(posedge clk_in);
    pin <= 1'b0;
    host_write('{channel: 3'h7, software_start_bit: 1'b0, standby: 1'b1});
    check("standby", 1'b1, stby);
    repeat (ACQ_TIME_CYCLES) @(posedge clk_in);
    t_hw(12'h801);
  endtask
  task automatic t_self;
    @(posedge clk_in);
    self_mode <= 1'b1;
    t_hw(12'h07F);
    check("frame_sync", 1'b0, rfs_n);
    @(posedge clk_in);
    fdone <= 1'b1;
    @(posedge clk_in);
    fdone <= 1'b0;
    #1 check("frame_sync", 1'b1, rfs_n);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    #1 check("reset_pin", 1'b1, tcap);
    check("reset_status", 16'h0004, 16'(stat));
    check("reset_outputs", 16'h2000, {1'b0, hold, rfs_n, eoc, result});
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_hw(12'hFFF);
    t_hw(12'h000);
    t_settle;
    t_sw;
    t_self;
    finish_test;
  end
endmodule
bind adc_conversion_sequencer adc_seq_chk #(.BIPOLAR(BIPOLAR)) adc_seq_chk_inst (.clk_in, .arst_n_in,
  .conversion_start_pin_in, .master_clock_in, .write_begin_in, .sclk_fall_in, .write_word_in,
  .self_clock_mode_in, .raw_code_in, .timing_capacitor_pin_out, .track_hold_out, .receive_frame_sync_n_out,
  .result_out, .eoc_out, .status_out);
